// ### core/sscs_pkg.sv
// Purpose: Shared constants for the four-channel simultaneous-sample sequencer
// Assumes: Core clock at 20 MHz (50 ns period)
package sscs_pkg;

  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int CHANNELS       = 4;
  localparam int DATA_W         = 14;
  localparam int MASK_W         = 4;
  localparam int CLK_PERIOD_PS  = 50000;
  localparam int CONV_TIME_PS   = 2400000;
  localparam int ACQ_TIME_PS    = 350000;
  localparam int QUIET_TIME_PS  = 100000;
  // Least times round up to whole cycles
  localparam int CONV_CYCLES    = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACQ_CYCLES     = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUIET_CYCLES   = (QUIET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EOC_PULSE_CYC  = 1;
  localparam logic [MASK_W-1:0] MASK_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;

  // Sequencer states
  typedef enum logic [1:0] {
    SSCS_IDLE  = 2'b00,
    SSCS_CONV  = 2'b01,
    SSCS_NEXT  = 2'b10
  } sscs_state_t;

  // Host driver states
  typedef enum logic [2:0] {
    SSCS_H_IDLE  = 3'b000,
    SSCS_H_WRITE = 3'b001,
    SSCS_H_START = 3'b010,
    SSCS_H_WAIT  = 3'b011,
    SSCS_H_READ  = 3'b100,
    SSCS_H_ACQ   = 3'b101
  } sscs_host_state_t;

endpackage

// ### core/sscs_if.sv
// Purpose: Parallel link between converter sequencer and host
// Assumes: One clock for both ends
// Notes:   Resolves the shared data bus from both enables
`timescale 1ns/1ps
`default_nettype none
interface sscs_if;
  import sscs_pkg::*;
  logic                conversion_start_n;   // Start strobe, active low
  logic                cs_n;                 // Chip select
  logic                rd_n;                 // Read strobe
  logic                wr_n;                 // Write strobe
  logic                busy;                 // Sequence running
  logic                eoc_n;                // Per-channel done pulse
  logic [DATA_W-1:0]   dev_data;             // Device drive value
  logic                dev_data_oe;          // Device drives bus
  logic [MASK_W-1:0]   host_data;            // Host drive value, low lines
  logic                host_data_oe;         // Host drives low lines
  logic [DATA_W-1:0]   bus;                  // Resolved bus level

  // Bus resolution; undriven reads as zero
  always_comb
  begin
    bus = dev_data_oe ? dev_data : DATA_RESET;
    if (host_data_oe)
    begin
      bus[MASK_W-1:0] = host_data;
    end
  end

  modport device (input conversion_start_n, cs_n, rd_n, wr_n, bus,
                  output busy, eoc_n, dev_data, dev_data_oe);
  modport host   (output conversion_start_n, cs_n, rd_n, wr_n, host_data, host_data_oe,
                  input busy, eoc_n, bus);
endinterface
`default_nettype wire

// ### core/sscs_device.sv
// Purpose: Converter-side sequencer, selection latch, result store, readout
// Assumes: Link pins and clock option come from outside; all synchronised
// Notes:   Sample values come in as a parallel input per channel
`timescale 1ns/1ps
`default_nettype none
module sscs_device
  import sscs_pkg::*;
#(
  parameter int CONV_CYC = sscs_pkg::CONV_CYCLES
)(
  input  wire logic                  core_clk_in,            // 20 MHz clock
  input  wire logic                  rst_b_in,               // Async reset, low
  sscs_if.device                     link,                   // Host link
  input  wire logic [MASK_W-1:0]     pin_channel_mask_in,    // Hardware select pins
  input  wire logic                  select_source_in,       // 0 pins, 1 register
  input  wire logic                  clock_source_choice_in, // 1 external clock
  input  wire logic                  external_clock_input_in,// External conversion clock
  input  wire logic [4*DATA_W-1:0]   sample_in,              // Held samples, ch1 lowest
  output var  logic                  hold_out,               // Track/holds in hold
  output var  logic [MASK_W-1:0]     active_mask_out         // Latched selection
);
  import sscs_pkg::*;

  // Count must fit the 16-bit conversion counter
  if (CONV_CYC < 1 || CONV_CYC > 65536)
  begin : g_conv_cyc_check
    $error("CONV_CYC out of range");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] s1;
  logic [7:0] s2;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1 <= 8'hff;
      s2 <= 8'hff;
    end
    else
    begin
      s1 <= {link.conversion_start_n, link.cs_n, link.rd_n, link.wr_n,
             select_source_in, clock_source_choice_in, external_clock_input_in, 1'b1};
      s2 <= s1;
    end
  end
  logic start_n_s, cs_n_s, rd_n_s, wr_n_s, src_s, clk_sel_s, ext_clk_s;
  assign {start_n_s, cs_n_s, rd_n_s, wr_n_s, src_s, clk_sel_s, ext_clk_s} = s2[7:1];

  logic [MASK_W-1:0] pm1;
  logic [MASK_W-1:0] pm2;
  logic [MASK_W-1:0] db1;
  logic [MASK_W-1:0] db2;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pm1 <= MASK_RESET;
      pm2 <= MASK_RESET;
      db1 <= MASK_RESET;
      db2 <= MASK_RESET;
    end
    else
    begin
      pm1 <= pin_channel_mask_in;
      pm2 <= pm1;
      db1 <= link.bus[MASK_W-1:0];
      db2 <= db1;
    end
  end

  // Edge history of synchronised strobes
  logic start_n_d, wr_n_d, rd_n_d, ext_clk_d;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      start_n_d <= 1'b1;
      wr_n_d    <= 1'b1;
      rd_n_d    <= 1'b1;
      ext_clk_d <= 1'b1;  // Matches sync reset, no false tick
    end
    else
    begin
      start_n_d <= start_n_s;
      wr_n_d    <= wr_n_s;
      rd_n_d    <= rd_n_s;
      ext_clk_d <= ext_clk_s;
    end
  end
  logic start_rise, wr_rise, rd_rise, ext_tick;
  assign start_rise = start_n_s & ~start_n_d;
  assign wr_rise    = wr_n_s & ~wr_n_d & ~cs_n_s;
  assign rd_rise    = rd_n_s & ~rd_n_d & ~cs_n_s;
  assign ext_tick   = ext_clk_s & ~ext_clk_d;

  // ----------------------------------------
  // Channel select register
  // ----------------------------------------
  logic [MASK_W-1:0] channel_select;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      channel_select <= MASK_RESET;
    else if (wr_rise)
      channel_select <= db2;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  sscs_state_t       state;
  logic [MASK_W-1:0] pending;
  logic [1:0]        cur_ch;
  logic [15:0]       conv_cnt;
  logic              tick;
  logic [1:0]        lowest;

  // external clock edges only when chosen
  assign tick = clk_sel_s ? ext_tick : 1'b1;

  always_comb
  begin
    lowest = 2'd3;
    for (int i = CHANNELS - 1; i >= 0; i--)
      if (pending[i]) lowest = 2'(i);
  end

  logic [DATA_W-1:0] result [CHANNELS];
  logic [2:0]        stored;
  logic [1:0]        rd_ptr;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state           <= SSCS_IDLE;
      pending         <= MASK_RESET;
      cur_ch          <= 2'd0;
      conv_cnt        <= 16'h0000;
      hold_out        <= 1'b0;
      active_mask_out <= MASK_RESET;
      link.busy       <= 1'b0;
      link.eoc_n      <= 1'b1;
      stored          <= 3'd0;
      for (int i = 0; i < CHANNELS; i++) result[i] <= DATA_RESET;
    end
    else
    begin
      link.eoc_n <= 1'b1;
      case (state)
        SSCS_IDLE:
        begin
          if (start_rise)
          begin
            hold_out <= 1'b1;
            link.busy <= 1'b1;
            stored    <= 3'd0;
            pending         <= src_s ? channel_select : pm2;
            active_mask_out <= src_s ? channel_select : pm2;
            state           <= SSCS_NEXT;
          end
        end
        SSCS_NEXT:
        begin
          if (pending == MASK_RESET)
          begin
            link.busy <= 1'b0;
            hold_out  <= 1'b0;
            state     <= SSCS_IDLE;
          end
          else
          begin
            cur_ch   <= lowest;
            conv_cnt <= 16'h0000;
            state    <= SSCS_CONV;
          end
        end
        SSCS_CONV:
        begin
          if (tick)
          begin
            if (conv_cnt >= 16'(CONV_CYC - 1))
            begin
              // mask bit i is channel i+1
              result[stored[1:0]] <= sample_in[cur_ch*DATA_W +: DATA_W];
              stored              <= stored + 3'd1;
              pending[cur_ch]     <= 1'b0;
              link.eoc_n <= 1'b0;
              state      <= SSCS_NEXT;
            end
            else
              conv_cnt <= conv_cnt + 16'd1;
          end
        end
        default: state <= SSCS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Readout
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rd_ptr <= 2'd0;
    else if (start_rise && state == SSCS_IDLE)
      rd_ptr <= 2'd0;
    else if (rd_rise)
      rd_ptr <= rd_ptr + 2'd1;
  end

  // drive result while selected and reading
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      link.dev_data    <= DATA_RESET;
      link.dev_data_oe <= 1'b0;
    end
    else
    begin
      link.dev_data    <= result[rd_ptr];
      link.dev_data_oe <= ~cs_n_s & ~rd_n_s;
    end
  end
endmodule
`default_nettype wire

// ### core/sscs_host.sv
// Purpose: Host end: writes selection, starts sequences, reads results
// Assumes: Same core clock as device; busy and eoc_n synchronised here, bus sampled directly
// Notes:   One user command runs a whole sequence and read-back
`timescale 1ns/1ps
`default_nettype none
module sscs_host
  import sscs_pkg::*;
(
  input  wire logic                core_clk_in,     // 20 MHz clock
  input  wire logic                rst_b_in,        // Async reset, low
  sscs_if.host                     link,            // Device link
  input  wire logic                go_in,           // Pulse: run one sequence
  input  wire logic                write_sel_in,    // Write register first
  input  wire logic [MASK_W-1:0]   sel_mask_in,     // Mask to write / count
  output var  logic                ready_out,       // Idle, accepts go
  output var  logic                result_valid_out,// Result pulse
  output var  logic [DATA_W-1:0]   result_out       // Read result
);
  import sscs_pkg::*;

  // Synchronise device outputs
  logic [1:0] b1;
  logic [1:0] b2;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      b1 <= 2'b01;
      b2 <= 2'b01;
    end
    else
    begin
      b1 <= {link.busy, link.eoc_n};
      b2 <= b1;
    end
  end

  sscs_host_state_t  state;
  logic [7:0]        cnt;
  logic [2:0]        left;
  logic              seen_busy;
  logic [MASK_W-1:0] mask;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state                   <= SSCS_H_IDLE;
      cnt                     <= 8'h00;
      left                    <= 3'd0;
      seen_busy               <= 1'b0;
      mask                    <= MASK_RESET;
      link.conversion_start_n <= 1'b1;
      link.cs_n               <= 1'b1;
      link.rd_n               <= 1'b1;
      link.wr_n               <= 1'b1;
      link.host_data          <= MASK_RESET;
      link.host_data_oe       <= 1'b0;
      ready_out               <= 1'b0;
      result_valid_out        <= 1'b0;
      result_out              <= DATA_RESET;
    end
    else
    begin
      result_valid_out <= 1'b0;
      cnt              <= cnt + 8'd1;
      case (state)
        SSCS_H_IDLE:
        begin
          ready_out <= 1'b1;
          if (go_in)
          begin
            ready_out <= 1'b0;
            mask      <= sel_mask_in;
            left      <= 3'(sel_mask_in[0]) + 3'(sel_mask_in[1])
                       + 3'(sel_mask_in[2]) + 3'(sel_mask_in[3]);
            cnt       <= 8'h00;
            state     <= write_sel_in ? SSCS_H_WRITE : SSCS_H_START;
          end
        end
        SSCS_H_WRITE:
        begin
          link.host_data    <= mask;
          link.host_data_oe <= 1'b1;
          link.cs_n         <= cnt > 8'd7;
          link.wr_n         <= ~(cnt > 8'd1 && cnt < 8'd6);
          if (cnt == 8'd9)
          begin
            link.host_data_oe <= 1'b0;
            cnt               <= 8'h00;
            state             <= SSCS_H_START;
          end
        end
        SSCS_H_START:
        begin
          link.conversion_start_n <= ~(cnt < 8'd4);
          seen_busy               <= 1'b0;
          if (cnt == 8'd4)
            state <= SSCS_H_WAIT;
        end
        SSCS_H_WAIT:
        begin
          if (b2[1])
            seen_busy <= 1'b1;
          if (seen_busy && !b2[1])
          begin
            cnt   <= 8'h00;
            state <= (left == 3'd0) ? SSCS_H_ACQ : SSCS_H_READ;
          end
        end
        SSCS_H_READ:
        begin
          link.cs_n <= cnt > 8'd7;
          link.rd_n <= ~(cnt > 8'd1 && cnt < 8'd6);
          // Device drives three cycles after the strobe falls; sample mid-window
          if (cnt == 8'd7)
          begin
            result_out       <= link.bus;
            result_valid_out <= 1'b1;
          end
          if (cnt == 8'd9)
          begin
            cnt  <= 8'h00;
            left <= left - 3'd1;
            if (left == 3'd1)
              state <= SSCS_H_ACQ;
          end
        end
        SSCS_H_ACQ:
        begin
          if (cnt >= 8'(ACQ_CYCLES + QUIET_CYCLES))
            state <= SSCS_H_IDLE;
        end
        default: state <= SSCS_H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/sscs_link_props.sv
// Purpose: Link checker for the sequencer pair
// Assumes: One clock domain, async low reset
// Notes:   Sees only link signals, no bind
`timescale 1ns/1ps
`default_nettype none
module sscs_link_props
#(
  parameter int CONV_CYC = 4
)(
  input  wire logic core_clk_in,        // Core clock
  input  wire logic rst_b_in,           // Reset, low
  input  wire logic conversion_start_n, // Start strobe
  input  wire logic cs_n,               // Chip select
  input  wire logic rd_n,               // Read strobe
  input  wire logic wr_n,               // Write strobe
  input  wire logic busy,               // Sequence running
  input  wire logic eoc_n,              // Done pulse
  input  wire logic dev_data_oe,        // Device drives bus
  input  wire logic host_data_oe        // Host drives bus
);
  logic [7:0] gap_cnt;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // ----------------------------------------
  // Conversion spacing counter
  // ----------------------------------------
  // Cycles since busy rose or the last result; saturates
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      gap_cnt <= 8'h00;
    else if (!busy || !eoc_n)
      gap_cnt <= 8'h00;
    else if (gap_cnt != 8'hff)
      gap_cnt <= gap_cnt + 8'h01;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_START_BUSY: assert property ($rose(conversion_start_n) && !busy |-> ##[2:4] busy)
    else $error("busy did not follow start");
  AST_BUSY_ENDS: assert property ($rose(busy) |-> ##[1:600] !busy)
    else $error("busy never ended");
  AST_EOC_ONE: assert property ($fell(eoc_n) |=> eoc_n)
    else $error("done pulse too long");
  AST_EOC_IN_SEQ: assert property (!eoc_n |-> busy)
    else $error("done pulse outside sequence");
  AST_CONV_TIME: assert property ($fell(eoc_n) |-> gap_cnt >= CONV_CYC - 1)
    else $error("conversion too short");
  AST_OE_CAUSE: assert property (dev_data_oe |-> $past(!cs_n && !rd_n, 3))
    else $error("device drove bus unasked");
  AST_NO_FIGHT: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive bus");
  AST_WR_DATA: assert property ($rose(wr_n) && !cs_n |-> $past(host_data_oe))
    else $error("write without data");
  AST_READ_IDLE: assert property (!cs_n && !rd_n |-> !busy)
    else $error("read during conversion");
  AST_ACQ_GAP: assert property ($fell(busy) |=> (!$rose(conversion_start_n))[*7])
    else $error("start within acquisition");

  // Main scenarios reached
  cover property ($fell(busy));
  cover property ($fell(eoc_n));
  cover property ($rose(wr_n) && !cs_n);
  cover property (dev_data_oe ##1 !dev_data_oe);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for host and device joined by the link
// Assumes: 20 MHz clock, short conversion count
// Notes:   Host runs read-back after busy only
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sscs_pkg::*;
  localparam int CONV = 4;
  logic                  core_clk_in = 1'b0;
  logic                  rst_b_in    = 1'b0;
  logic                  go = 1'b0, wsel = 1'b0, src = 1'b0, clk_sel = 1'b0, ext_clk = 1'b0;
  logic [MASK_W-1:0]     pin = 4'h0, smask = 4'h0, reg_mask = 4'h0, amask;
  logic                  hold, rdy, rv;
  logic [DATA_W-1:0]     res;
  logic [4*DATA_W-1:0]   samples = {14'h3f01, 14'h0e7f, 14'h2c3d, 14'h1a5b};
  int                    error_cnt = 0, checks_done = 0, eoc_tot = 0, busy_tot = 0;

  // ----------------------------------------
  // Clocks, counters, instances
  // ----------------------------------------
  always #25 core_clk_in = ~core_clk_in;
  // External conversion clock at half core rate
  always @(posedge core_clk_in) ext_clk <= ~ext_clk;
  // Counted at negedge so design updates have landed
  always @(negedge core_clk_in)
  begin
    if (i_sscs_if.eoc_n === 1'b0) eoc_tot++;
    if (i_sscs_if.busy === 1'b1) busy_tot++;
  end

  sscs_if i_sscs_if ();
  sscs_device #(.CONV_CYC(CONV)) i_sscs_device (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .link(i_sscs_if), .pin_channel_mask_in(pin),
    .select_source_in(src), .clock_source_choice_in(clk_sel),
    .external_clock_input_in(ext_clk), .sample_in(samples), .hold_out(hold),
    .active_mask_out(amask));
  sscs_host i_sscs_host (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link(i_sscs_if),
    .go_in(go), .write_sel_in(wsel), .sel_mask_in(smask), .ready_out(rdy),
    .result_valid_out(rv), .result_out(res));
  sscs_link_props #(.CONV_CYC(CONV)) i_sscs_link_props (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .conversion_start_n(i_sscs_if.conversion_start_n),
    .cs_n(i_sscs_if.cs_n), .rd_n(i_sscs_if.rd_n), .wr_n(i_sscs_if.wr_n),
    .busy(i_sscs_if.busy), .eoc_n(i_sscs_if.eoc_n), .dev_data_oe(i_sscs_if.dev_data_oe),
    .host_data_oe(i_sscs_if.host_data_oe));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                       input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait for an idle host
  task automatic wait_ready;
    int t;
    t = 0;
    while (rdy !== 1'b1 && t < 3000)
    begin
      @(negedge core_clk_in);
      t++;
    end
    if (rdy !== 1'b1) check(14'h0, 14'h1, "ready timeout");
  endtask

  // One sequence: optional write, start, read-back, then judge
  task automatic run_seq(input logic s, input logic [3:0] pins, input logic w,
                         input logic [3:0] m, input logic ext, input logic chg,
                         input string name);
    logic [3:0] em;
    int e0, b0, n, k, t;
    em = s ? (w ? m : reg_mask) : pins;
    n = $countones(em);
    wait_ready;
    @(posedge core_clk_in);
    src <= s; pin <= pins; wsel <= w; smask <= m; clk_sel <= ext; go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    e0 = eoc_tot;
    b0 = busy_tot;
    t = 0;
    while (i_sscs_if.busy !== 1'b1 && t < 300)
    begin
      @(negedge core_clk_in);
      t++;
    end
    check({13'h0, hold}, 14'h1, "holds taken");
    if (chg)
    begin
      // Flip pins mid-sequence; must not disturb the latched set
      t = 0;
      while (i_sscs_if.busy !== 1'b1 && t < 300) begin @(negedge core_clk_in); t++; end
      @(posedge core_clk_in);
      pin <= ~pins;
    end
    for (k = 0; k < 4; k++)
    begin
      if (em[k])
      begin
        t = 0;
        while (rv !== 1'b1 && t < 3000) begin @(negedge core_clk_in); t++; end
        check(res, samples[k*DATA_W +: DATA_W], name);
        @(negedge core_clk_in);
      end
    end
    wait_ready;
    check(14'(eoc_tot - e0), 14'(n), "done pulse count");
    check({10'h0, amask}, {10'h0, em}, "latched selection");
    check({13'h0, hold}, 14'h0, "holds back to track");
    check({13'h0, (busy_tot - b0) >= (ext ? 2 : 1) * n * CONV}, 14'h1, "busy length");
    if (w) reg_mask = m;
    $display("test %s done", name);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // register written, gaps in mask
  task automatic t_soft_mask; run_seq(1'b1, 4'h2, 1'b1, 4'hd, 1'b0, 1'b0, "soft"); endtask
  task automatic t_pin_mask;  run_seq(1'b0, 4'h6, 1'b0, 4'h6, 1'b0, 1'b0, "pins"); endtask
  task automatic t_latch;     run_seq(1'b0, 4'h8, 1'b0, 4'h8, 1'b0, 1'b1, "latch"); endtask
  task automatic t_reg_kept;  run_seq(1'b1, 4'h1, 1'b0, 4'hd, 1'b0, 1'b0, "regkeep"); endtask
  // all four on the external clock
  task automatic t_ext_clk;   run_seq(1'b1, 4'h0, 1'b1, 4'hf, 1'b1, 1'b0, "extclk"); endtask

  // Hang guard, far beyond five short sequences
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    check(14'h0, 14'h1, "watchdog");
    final_report;
  end

  initial
  begin
    repeat (5) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_soft_mask;
    t_pin_mask;
    t_latch;
    t_reg_kept;
    t_ext_clk;
    final_report;
  end
endmodule
`default_nettype wire
